// File: logic/lbs_left_bank.sv
`timescale 1ns/1ps
module lbs_left_bank
   import lbs_pkg::*;
(
   // system
   input  wire logic                  clk,
   input  wire logic                  rst,
   // serial link
   input  wire logic                  spiClk,
   input  wire logic                  serialIn,
   input  wire logic                  slave_select_low,
   output logic                       serialOut,
   output logic                       serial_out_enable,
   // fabric byte ports and bus
   output logic [7:0]                 fabric_gp_out,
   input  wire logic [7:0]            fabric_gp_in,
   output logic [7:0]                 fabric_ctrl_byte,
   output logic [7:0]                 fabric_bus_addr,
   output logic [7:0]                 fabric_bus_wdata,
   input  wire logic [7:0]            fabric_bus_rdata,
   output logic                       fabric_bus_req,
   input  wire logic                  fabric_bus_ack,
   output logic                       fabric_bus_read_not_write,
   // shared buffer RAM fabric ports
   input  wire logic                  buf_rport_owner_sel,
   input  wire logic                  buf_wport_clk,
   input  wire logic [BUF_AW-1:0]     buf_wport_addr,
   input  wire logic [WORD_W-1:0]     buf_wport_wdata,
   input  wire logic                  buf_wport_we,
   input  wire logic [BE_W-1:0]       buf_wport_be,
   input  wire logic [BUF_AW-1:0]     bufRportAddr,
   input  wire logic                  buf_rport_re,
   output logic [WORD_W-1:0]          buf_rport_rdata,
   // auxiliary single-port RAM fabric port
   input  wire logic                  auxClk,
   input  wire logic [AUX_AW-1:0]     auxAddr,
   input  wire logic [AUX_DW-1:0]     auxWdata,
   input  wire logic                  auxWe,
   input  wire logic                  auxRe,
   input  wire logic [BE_W-1:0]       auxBe,
   output logic [AUX_DW-1:0]          auxRdata,
   // tie-offs
   input  wire logic                  spi_space_extend_opt,
   input  wire logic                  fabric_buf_read_opt,
   input  wire logic [31:0]           device_ident_in,
   input  wire logic [7:0]            platform_ident_in,
   input  wire logic                  serial_phase_tie,
   input  wire logic                  serial_polarity_tie,
   input  wire logic                  serial_lsb_first_tie
);

   // memories
   logic [WORD_W-1:0] bufMem [BUF_DEPTH];
   logic [AUX_DW-1:0] auxMem [AUX_DEPTH];

   // serial-domain state
   logic              frameRst;
   logic [2:0]        bitCnt_q;
   logic [6:0]        shiftIn_q;
   logic [7:0]        rxByte;
   logic              byteDone;
   lbs_phase_t        phase_q;
   logic [7:0]        cmd_q;
   logic [2:0]        respCnt_q;
   logic [1:0]        lane_q;
   logic [SPI_AW-1:0] memAddr_q;
   logic [WORD_W-1:0] wordHold_q, wordRd;
   logic [7:0]        txByte_q, nextTx;
   logic              serialOut_q, outEn_q;
   logic [7:0]        gpOut_q, ctrl_q, fabricAddr_q, spiWdata_q;
   logic              spiRnw_q, reqTgl_q, doneSync1_q, doneSync2_q, doneSeen_q;
   logic [7:0]        gpInSync1_q, gpInSync2_q;
   logic              busy, doneEdge, issueWr, issueRd;
   logic [7:0]        statusByte;

   // system-domain state
   lbs_fbus_t         fbState_q;
   logic              reqSync1_q, reqSync2_q, reqSeen_q, doneTgl_q;
   logic [7:0]        busAddr_q, busWdata_q;
   logic              busRnw_q, busReq_q;
   logic [7:0]        rdHold_q;

   // fabric-clock outputs
   logic [WORD_W-1:0] bufRdata_q;
   logic [AUX_DW-1:0] auxRdata_q;

   // deselect ends the frame asynchronously; the serial clock may stop outside frames
   assign frameRst = rst | slave_select_low;
   assign rxByte   = {shiftIn_q, serialIn};
   assign byteDone = (bitCnt_q == 3'h7);

   always_ff @(posedge spiClk or posedge frameRst) begin
      if (frameRst) begin
         bitCnt_q  <= 3'h0;
         shiftIn_q <= 7'h00;
      end else begin
         bitCnt_q  <= bitCnt_q + 3'h1;
         shiftIn_q <= rxByte[6:0];
      end
   end

   // mode 0: drive on the falling edge, msb first
   always_ff @(negedge spiClk or posedge frameRst) begin
      if (frameRst) begin
         serialOut_q <= 1'b0;
         outEn_q     <= 1'b0;
      end else begin
         serialOut_q <= txByte_q[~bitCnt_q];
         outEn_q     <= 1'b1;
      end
   end

   function automatic logic [WORD_W-1:0] readWord(input logic [SPI_AW-1:0] a);
      logic [WORD_W-1:0] w;
      w = '0;
      if (buf_rport_owner_sel) begin
         w = '0;
      end else if (!spi_space_extend_opt) begin
         w = bufMem[a[BUF_AW-1:0]];
      end else if (!a[11]) begin
         w = bufMem[a[BUF_AW-1:0]];
      end else if (a[10:9] == 2'b00) begin
         w = auxMem[a[AUX_AW-1:0]][WORD_W-1:0];
      end
      return w;
   endfunction : readWord

   assign busy       = reqTgl_q ^ doneSync2_q;
   assign doneEdge   = doneSync2_q ^ doneSeen_q;
   assign statusByte = {3'h0, serial_lsb_first_tie, serial_polarity_tie, serial_phase_tie,
                        spi_space_extend_opt, busy};

   always_comb begin
      wordRd = readWord((phase_q == PH_ADDRL) ? {memAddr_q[15:8], rxByte} : memAddr_q);
      nextTx = 8'h00;
      case (phase_q)
         PH_CMD: begin
            case (rxByte)
               CMD_GP_IN_RD:  nextTx = gpInSync2_q;
               CMD_STATUS_RD: nextTx = statusByte;
               CMD_FBUS_DATA: nextTx = rdHold_q;
               CMD_IDENT_RD:  nextTx = device_ident_in[31:24];
               default:       nextTx = 8'h00;
            endcase
         end
         PH_ADDRL: nextTx = wordRd[31:24];
         PH_DATA: begin
            if (cmd_q == CMD_MEM_RD) begin
               if (lane_q == 2'h0) begin
                  nextTx = wordRd[31:24];
               end else begin
                  nextTx = wordHold_q[(3 - lane_q) * 8 +: 8];
               end
            end else if (cmd_q == CMD_IDENT_RD) begin
               case (respCnt_q)
                  3'h1:           nextTx = device_ident_in[23:16];
                  3'h2:           nextTx = device_ident_in[15:8];
                  3'h3:           nextTx = device_ident_in[7:0];
                  IDENT_PLAT_IDX: nextTx = platform_ident_in;
                  default:        nextTx = 8'h00;
               endcase
            end
         end
         default: nextTx = 8'h00;
      endcase
   end

   always_ff @(posedge spiClk or posedge frameRst) begin
      if (frameRst) begin
         phase_q    <= PH_CMD;
         cmd_q      <= 8'h00;
         respCnt_q  <= 3'h0;
         lane_q     <= 2'h0;
         memAddr_q  <= '0;
         wordHold_q <= '0;
         txByte_q   <= 8'h00;
      end else if (byteDone) begin
         txByte_q <= nextTx;
         case (phase_q)
            PH_CMD: begin
               cmd_q     <= rxByte;
               respCnt_q <= 3'h1;
               phase_q   <= (rxByte == CMD_MEM_RD) ? PH_ADDRH : PH_DATA;
            end
            PH_ADDRH: begin
               memAddr_q[15:8] <= rxByte;
               phase_q         <= PH_ADDRL;
            end
            PH_ADDRL: begin
               memAddr_q[7:0] <= rxByte;
               wordHold_q     <= wordRd;
               lane_q         <= 2'h1;
               phase_q        <= PH_DATA;
            end
            PH_DATA: begin
               if (respCnt_q != 3'h7) begin
                  respCnt_q <= respCnt_q + 3'h1;
               end
               if (cmd_q == CMD_MEM_RD) begin
                  if (lane_q == 2'h0) begin
                     wordHold_q <= wordRd;
                  end
                  if (lane_q == 2'h3) begin
                     // wraps across 64K; mapping mirrors the space
                     memAddr_q <= memAddr_q + 16'h0001;
                  end
                  lane_q <= lane_q + 2'h1;
               end
            end
            default: phase_q <= PH_CMD;
         endcase
      end
   end

   always_ff @(posedge spiClk or posedge rst) begin
      if (rst) begin
         gpOut_q <= GP_OUT_RST;
         ctrl_q  <= CTRL_RST;
      end else if (byteDone && (phase_q == PH_DATA)) begin
         if (cmd_q == CMD_GP_OUT_WR) begin
            gpOut_q <= rxByte;
         end
         if (cmd_q == CMD_CTRL_WR) begin
            ctrl_q <= rxByte;
         end
      end
   end

   always_ff @(posedge spiClk or posedge rst) begin
      if (rst) begin
         gpInSync1_q <= 8'h00;
         gpInSync2_q <= 8'h00;
         doneSync1_q <= 1'b0;
         doneSync2_q <= 1'b0;
      end else begin
         gpInSync1_q <= fabric_gp_in;
         gpInSync2_q <= gpInSync1_q;
         doneSync1_q <= doneTgl_q;
         doneSync2_q <= doneSync1_q;
      end
   end

   // one access in flight; a request arriving while busy is dropped
   assign issueWr = byteDone && (phase_q == PH_DATA) && (cmd_q == CMD_FBUS_WR) && !busy;
   assign issueRd = byteDone && (phase_q == PH_CMD) && (rxByte == CMD_FBUS_RD) && !busy;

   always_ff @(posedge spiClk or posedge rst) begin
      if (rst) begin
         fabricAddr_q <= FADDR_RST;
         spiWdata_q   <= 8'h00;
         spiRnw_q     <= 1'b0;
         reqTgl_q     <= 1'b0;
         doneSeen_q   <= 1'b0;
      end else begin
         doneSeen_q <= doneSync2_q;
         if (byteDone && (phase_q == PH_DATA) && (cmd_q == CMD_FADDR_WR)) begin
            fabricAddr_q <= rxByte;
         end else if (doneEdge) begin
            fabricAddr_q <= fabricAddr_q + 8'h01;
         end
         if (issueWr) begin
            spiWdata_q <= rxByte;
            spiRnw_q   <= 1'b0;
            reqTgl_q   <= ~reqTgl_q;
         end else if (issueRd) begin
            spiRnw_q <= 1'b1;
            reqTgl_q <= ~reqTgl_q;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reqSync1_q <= 1'b0;
         reqSync2_q <= 1'b0;
      end else begin
         reqSync1_q <= reqTgl_q;
         reqSync2_q <= reqSync1_q;
      end
   end

   // serial-side data and direction stay still until the done toggle returns; the address can still be rewritten by CMD_FADDR_WR
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fbState_q  <= FB_IDLE;
         reqSeen_q  <= 1'b0;
         doneTgl_q  <= 1'b0;
         busAddr_q  <= FADDR_RST;
         busWdata_q <= 8'h00;
         busRnw_q   <= 1'b0;
         busReq_q   <= 1'b0;
         rdHold_q   <= 8'h00;
      end else begin
         case (fbState_q)
            FB_IDLE: begin
               if (reqSync2_q ^ reqSeen_q) begin
                  reqSeen_q  <= reqSync2_q;
                  busAddr_q  <= fabricAddr_q;
                  busWdata_q <= spiWdata_q;
                  busRnw_q   <= spiRnw_q;
                  busReq_q   <= 1'b1;
                  fbState_q  <= FB_REQ;
               end
            end
            FB_REQ: begin
               if (fabric_bus_ack) begin
                  if (busRnw_q) begin
                     rdHold_q <= fabric_bus_rdata;
                  end
                  busReq_q  <= 1'b0;
                  fbState_q <= FB_RELEASE;
               end
            end
            FB_RELEASE: begin
               // full four-phase: wait for acknowledge to fall
               if (!fabric_bus_ack) begin
                  doneTgl_q <= ~doneTgl_q;
                  fbState_q <= FB_IDLE;
               end
            end
            default: fbState_q <= FB_IDLE;
         endcase
      end
   end

   always_ff @(posedge buf_wport_clk) begin
      if (buf_wport_we) begin
         for (int i = 0; i < BE_W; i++) begin
            if (buf_wport_be[i]) begin
               bufMem[buf_wport_addr][i * 8 +: 8] <= buf_wport_wdata[i * 8 +: 8];
            end
         end
      end
   end

   // read port timed by the port-0 clock in both borrowed and owner modes
   always_ff @(posedge buf_wport_clk or posedge rst) begin
      if (rst) begin
         bufRdata_q <= '0;
      end else if (buf_rport_re && fabric_buf_read_opt) begin
         bufRdata_q <= bufMem[buf_wport_addr];
      end else if (buf_rport_re && buf_rport_owner_sel) begin
         bufRdata_q <= bufMem[bufRportAddr];
      end
   end

   always_ff @(posedge auxClk) begin
      if (auxWe) begin
         for (int i = 0; i < BE_W; i++) begin
            if (auxBe[i]) begin
               auxMem[auxAddr][i * AUX_LANE_W +: AUX_LANE_W] <=
                  auxWdata[i * AUX_LANE_W +: AUX_LANE_W];
            end
         end
      end
   end

   always_ff @(posedge auxClk or posedge rst) begin
      if (rst) begin
         auxRdata_q <= '0;
      end else if (auxRe) begin
         auxRdata_q <= auxMem[auxAddr];
      end
   end

   assign serialOut                 = serialOut_q;
   assign serial_out_enable         = outEn_q;
   assign fabric_gp_out             = gpOut_q;
   assign fabric_ctrl_byte          = ctrl_q;
   assign fabric_bus_addr           = busAddr_q;
   assign fabric_bus_wdata          = busWdata_q;
   assign fabric_bus_req            = busReq_q;
   assign fabric_bus_read_not_write = busRnw_q;
   assign buf_rport_rdata           = bufRdata_q;
   assign auxRdata                  = auxRdata_q;

endmodule : lbs_left_bank

// File: logic/lbs_pkg.sv
package lbs_pkg;

   // memory geometry
   localparam int BUF_AW     = 11;
   localparam int BUF_DEPTH  = 2048;
   localparam int AUX_AW     = 9;
   localparam int AUX_DEPTH  = 512;
   localparam int AUX_DW     = 36;
   localparam int AUX_LANE_W = 9;
   localparam int WORD_W     = 32;
   localparam int BE_W       = 4;
   localparam int SPI_AW     = 16;

   // serial command codes
   localparam logic [7:0] CMD_GP_OUT_WR  = 8'h01;
   localparam logic [7:0] CMD_CTRL_WR    = 8'h02;
   localparam logic [7:0] CMD_FADDR_WR   = 8'h03;
   localparam logic [7:0] CMD_FBUS_WR    = 8'h04;
   localparam logic [7:0] CMD_FBUS_RD    = 8'h05;
   localparam logic [7:0] CMD_FBUS_DATA  = 8'h06;
   localparam logic [7:0] CMD_GP_IN_RD   = 8'h07;
   localparam logic [7:0] CMD_STATUS_RD  = 8'h08;
   localparam logic [7:0] CMD_IDENT_RD   = 8'h09;
   localparam logic [7:0] CMD_MEM_RD     = 8'h0B;

   // reset values
   localparam logic [7:0] GP_OUT_RST     = 8'h00;
   localparam logic [7:0] CTRL_RST       = 8'h00;
   localparam logic [7:0] FADDR_RST      = 8'h00;

   // ident response byte holding the platform code
   localparam logic [2:0] IDENT_PLAT_IDX = 3'h4;

   typedef enum logic [3:0] {
      PH_CMD   = 4'b0001,
      PH_ADDRH = 4'b0010,
      PH_ADDRL = 4'b0100,
      PH_DATA  = 4'b1000
   } lbs_phase_t;

   typedef enum logic [2:0] {
      FB_IDLE    = 3'b001,
      FB_REQ     = 3'b010,
      FB_RELEASE = 3'b100
   } lbs_fbus_t;

endpackage : lbs_pkg

// File: sim/lbs_left_bank_props.sv
`timescale 1ns/1ps
module lbs_left_bank_props (
   // clocks and reset
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       spiClk,
   // serial link
   input wire logic       slave_select_low,
   input wire logic       serialOut,
   input wire logic       serial_out_enable,
   // fabric side
   input wire logic [7:0] fabric_gp_out,
   input wire logic [7:0] fabric_ctrl_byte,
   input wire logic [7:0] fabric_bus_addr,
   input wire logic [7:0] fabric_bus_wdata,
   input wire logic       fabric_bus_req,
   input wire logic       fabric_bus_ack,
   input wire logic       fabric_bus_read_not_write
);
   logic [2:0] edgeCnt_q;

   // rising edges seen in this frame, saturating
   always_ff @(posedge spiClk or posedge rst or posedge slave_select_low) begin
      if (rst || slave_select_low) begin
         edgeCnt_q <= 3'h0;
      end else if (edgeCnt_q != 3'h7) begin
         edgeCnt_q <= edgeCnt_q + 3'h1;
      end
   end

   property p_oe_deselect;
      @(posedge clk) disable iff (rst)
         slave_select_low |-> !serial_out_enable && !serialOut;
   endproperty
   a_oe_deselect: assert property (p_oe_deselect) else $error("output on while idle");
   property p_oe_frame;
      @(posedge spiClk) disable iff (rst) edgeCnt_q != 3'h0 |-> serial_out_enable;
   endproperty
   a_oe_frame: assert property (p_oe_frame) else $error("output off inside frame");
   property p_req_hold;
      @(posedge clk) disable iff (rst) fabric_bus_req && !fabric_bus_ack |=> fabric_bus_req;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped early");
   property p_req_drop;
      @(posedge clk) disable iff (rst) fabric_bus_req && fabric_bus_ack |=> !fabric_bus_req;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
   property p_req_qual;
      @(posedge clk) disable iff (rst)
         $changed({fabric_bus_addr, fabric_bus_wdata, fabric_bus_read_not_write})
         |-> $rose(fabric_bus_req);
   endproperty
   a_req_qual: assert property (p_req_qual) else $error("bus fields moved");
   property p_req_gap;
      @(posedge clk) disable iff (rst) $fell(fabric_bus_req) |=> !fabric_bus_req [*2];
   endproperty
   a_req_gap: assert property (p_req_gap) else $error("request reissued at once");
   property p_ack_phase;
      @(posedge clk) disable iff (rst) fabric_bus_ack |-> !$rose(fabric_bus_req);
   endproperty
   a_ack_phase: assert property (p_ack_phase) else $error("request while ack high");
   property p_regs_quiet;
      @(posedge clk) disable iff (rst) slave_select_low && $past(slave_select_low)
         |-> $stable(fabric_gp_out) && $stable(fabric_ctrl_byte);
   endproperty
   a_regs_quiet: assert property (p_regs_quiet) else $error("byte port moved idle");

   c_write: cover property (@(posedge clk) $rose(fabric_bus_req) && !fabric_bus_read_not_write);
   c_read: cover property (@(posedge clk) $rose(fabric_bus_req) && fabric_bus_read_not_write);
   c_frame: cover property (@(posedge spiClk) edgeCnt_q == 3'h7 && serial_out_enable);
endmodule : lbs_left_bank_props

bind lbs_left_bank lbs_left_bank_props i_lbs_left_bank_props (
   .clk, .rst, .spiClk, .slave_select_low, .serialOut, .serial_out_enable,
   .fabric_gp_out, .fabric_ctrl_byte, .fabric_bus_addr, .fabric_bus_wdata,
   .fabric_bus_req, .fabric_bus_ack, .fabric_bus_read_not_write
);

// File: sim/lbs_left_bank_test.sv
`timescale 1ns/1ps
module lbs_left_bank_test
   import lbs_pkg::*;
   ;
   // arbitrary identity values
   localparam logic [31:0] DEV_ID  = 32'h1234_5678;
   localparam logic [7:0]  PLAT_ID = 8'h3c;
   logic clk, rst, spiClk, serialIn, slave_select_low, serialOut, serial_out_enable;
   logic [7:0] fabric_gp_out, fabric_gp_in, fabric_ctrl_byte, fabric_bus_addr;
   logic [7:0] fabric_bus_wdata, fabric_bus_rdata, seenAddr, seenWdata, rdVal;
   logic fabric_bus_req, fabric_bus_ack, fabric_bus_read_not_write, seenRnw;
   logic buf_rport_owner_sel, buf_wport_we, buf_rport_re, auxWe, auxRe;
   logic spi_space_extend_opt, fabric_buf_read_opt;
   logic [BUF_AW-1:0] buf_wport_addr, bufRportAddr;
   logic [WORD_W-1:0] buf_wport_wdata, buf_rport_rdata;
   logic [BE_W-1:0] buf_wport_be, auxBe;
   logic [AUX_AW-1:0] auxAddr;
   logic [AUX_DW-1:0] auxWdata, auxRdata;
   int num_errors, checks_done, reqCount, ackDelay;

   lbs_left_bank i_lbs_left_bank (
      .clk, .rst, .spiClk, .serialIn, .slave_select_low, .serialOut, .serial_out_enable,
      .fabric_gp_out, .fabric_gp_in, .fabric_ctrl_byte, .fabric_bus_addr,
      .fabric_bus_wdata, .fabric_bus_rdata, .fabric_bus_req, .fabric_bus_ack,
      .fabric_bus_read_not_write, .buf_rport_owner_sel, .buf_wport_clk(clk),
      .buf_wport_addr, .buf_wport_wdata, .buf_wport_we, .buf_wport_be, .bufRportAddr,
      .buf_rport_re, .buf_rport_rdata, .auxClk(clk), .auxAddr, .auxWdata, .auxWe,
      .auxRe, .auxBe, .auxRdata, .spi_space_extend_opt, .fabric_buf_read_opt,
      .device_ident_in(DEV_ID), .platform_ident_in(PLAT_ID), .serial_phase_tie(1'b0),
      .serial_polarity_tie(1'b0), .serial_lsb_first_tie(1'b0)
   );
   lbs_spi_host_model i_lbs_spi_host_model (.spiClk, .serialIn, .slave_select_low, .serialOut);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // fabric responder, four-phase; data line inverted while not acknowledging
   initial begin
      forever begin
         @(posedge clk iff fabric_bus_req === 1'b1);
         seenAddr = fabric_bus_addr;
         seenRnw = fabric_bus_read_not_write;
         seenWdata = fabric_bus_wdata;
         repeat (ackDelay) @(posedge clk);
         #1;
         fabric_bus_ack = 1'b1;
         fabric_bus_rdata = rdVal;
         @(posedge clk iff fabric_bus_req === 1'b0);
         #1;
         fabric_bus_ack = 1'b0;
         fabric_bus_rdata = ~rdVal;
         reqCount++;
      end
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic give_verdict();
      $display("checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict

   // command byte, then the low n bytes of tx, highest byte first; replies land likewise
   task automatic frame(input logic [7:0] cmd, input logic [79:0] tx, input int n,
                        output logic [79:0] rx);
      logic [7:0] r;
      rx = '0;
      i_lbs_spi_host_model.open_frame();
      i_lbs_spi_host_model.xfer(cmd, r);
      for (int k = n - 1; k >= 0; k--) begin
         i_lbs_spi_host_model.xfer(tx[8*k+:8], r);
         rx[8*k+:8] = r;
      end
      i_lbs_spi_host_model.close_frame();
      chk(serial_out_enable, 1'b0);
      tick(8);
   endtask : frame

   task automatic mem_rd(input logic [15:0] a, output logic [31:0] w);
      logic [79:0] rx;
      frame(CMD_MEM_RD, {a, 32'h0}, 6, rx);
      w = rx[31:0];
   endtask : mem_rd

   // a new request only after the previous one has fully closed
   task automatic bus_op(input logic [7:0] cmd, input logic [7:0] d, input int n);
      logic [79:0] rx;
      int c;
      c = reqCount;
      frame(cmd, d, n, rx);
      for (int i = 0; i < 60 && reqCount == c; i++) tick(1);
      chk(reqCount, c + 1);
   endtask : bus_op

   task automatic buf_write(input logic [10:0] a, input logic [31:0] d, input logic [3:0] be);
      buf_wport_addr = a;
      buf_wport_wdata = d;
      buf_wport_be = be;
      buf_wport_we = 1'b1;
      tick(1);
      buf_wport_we = 1'b0;
   endtask : buf_write

   task automatic reboot(input logic ext, input logic rdOpt, input logic owner);
      rst = 1'b1;
      spi_space_extend_opt = ext;
      fabric_buf_read_opt = rdOpt;
      buf_rport_owner_sel = owner;
      tick(2);
      rst = 1'b0;
      tick(2);
   endtask : reboot

   task automatic t_regs();
      logic [79:0] rx;
      chk({fabric_gp_out, fabric_ctrl_byte, fabric_bus_addr, fabric_bus_wdata}, 0);
      chk({fabric_bus_req, fabric_bus_read_not_write, serial_out_enable, serialOut}, 0);
      frame(CMD_GP_OUT_WR, {8'h3c, 8'ha5}, 2, rx);
      chk(fabric_gp_out, 8'ha5);
      frame(CMD_CTRL_WR, 8'h81, 1, rx);
      chk(fabric_ctrl_byte, 8'h81);
      frame(CMD_CTRL_WR, 8'h00, 1, rx);
      chk(fabric_ctrl_byte, 8'h00);
      fabric_gp_in = 8'h96;
      frame(CMD_GP_IN_RD, 8'h00, 1, rx);
      chk(rx[7:0], 8'h96);
      frame(CMD_IDENT_RD, 80'h0, 5, rx);
      chk(rx[39:0], {DEV_ID, PLAT_ID});
   endtask : t_regs

   task automatic t_bus();
      logic [79:0] rx;
      frame(CMD_FADDR_WR, 8'hfe, 1, rx);
      ackDelay = 4;
      bus_op(CMD_FBUS_WR, 8'h5a, 1);
      chk({seenAddr, seenRnw, seenWdata}, {8'hfe, 1'b0, 8'h5a});
      ackDelay = 0;
      rdVal = 8'hc3;
      bus_op(CMD_FBUS_RD, 8'h00, 0);
      chk({seenAddr, seenRnw}, {8'hff, 1'b1});
      frame(CMD_FBUS_DATA, 8'h00, 1, rx);
      chk(rx[7:0], 8'hc3);
      bus_op(CMD_FBUS_WR, 8'h77, 1);
      chk({seenAddr, seenWdata}, {8'h00, 8'h77});
   endtask : t_bus

   task automatic t_mem();
      logic [79:0] rx;
      logic [31:0] w;
      buf_write(11'h000, 32'h1122_3344, 4'hf);
      buf_write(11'h000, 32'haabb_ccdd, 4'h5);
      buf_write(11'h7ff, 32'h0f0f_0f0f, 4'hf);
      frame(CMD_MEM_RD, {16'hffff, 64'h0}, 10, rx);
      chk(rx[63:32], 32'h0f0f_0f0f);
      chk(rx[31:0], 32'h11bb_33dd);
      reboot(1'b1, 1'b1, 1'b0);
      chk(fabric_gp_out, 8'h00);
      frame(CMD_STATUS_RD, 8'h00, 1, rx);
      chk(rx[7:0], 8'h02);
      auxAddr = 9'h003;
      auxWdata = 36'h9_8765_4321;
      auxBe = 4'hf;
      auxWe = 1'b1;
      tick(1);
      auxWe = 1'b0;
      mem_rd(16'h1803, w);
      chk(w, 32'h8765_4321);
      mem_rd(16'h1a00, w);
      chk(w, 32'h0000_0000);
      mem_rd(16'h3000, w);
      chk(w, 32'h11bb_33dd);
      auxRe = 1'b1;
      tick(1);
      auxRe = 1'b0;
      chk(auxRdata, 36'h9_8765_4321);
      buf_wport_addr = 11'h7ff;
      buf_rport_re = 1'b1;
      tick(1);
      buf_rport_re = 1'b0;
      chk(buf_rport_rdata, 32'h0f0f_0f0f);
      reboot(1'b0, 1'b0, 1'b1);
      mem_rd(16'h07ff, w);
      chk(w, 32'h0000_0000);
      bufRportAddr = 11'h000;
      buf_rport_re = 1'b1;
      tick(1);
      buf_rport_re = 1'b0;
      chk(buf_rport_rdata, 32'h11bb_33dd);
   endtask : t_mem

   initial begin
      {rst, fabric_gp_in, fabric_bus_rdata, fabric_bus_ack, rdVal} = {1'b1, 25'h0};
      {buf_rport_owner_sel, buf_wport_we, buf_rport_re, auxWe, auxRe} = 5'h0;
      {spi_space_extend_opt, fabric_buf_read_opt, auxBe, buf_wport_be} = 10'h0;
      {buf_wport_addr, bufRportAddr, buf_wport_wdata, auxAddr, auxWdata} = '0;
      {num_errors, checks_done, reqCount, ackDelay} = '0;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      tick(2);
      t_regs();
      t_bus();
      t_mem();
      give_verdict();
   end

   initial begin
      #1_000_000;
      num_errors++;
      $display("[ERR] %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule : lbs_left_bank_test

// File: sim/lbs_spi_host_model.sv
`timescale 1ns/1ps
module lbs_spi_host_model (
   // serial link
   output logic     spiClk,
   output logic     serialIn,
   output logic     slave_select_low,
   input wire logic serialOut
);
   int byteGap = 0;

   initial begin
      spiClk = 1'b0;
      serialIn = 1'b0;
      slave_select_low = 1'b1;
   end

   task automatic open_frame();
      slave_select_low = 1'b0;
      #40;
   endtask : open_frame

   // clock parks low between frames, data line no longer holds its value
   task automatic close_frame();
      #20;
      slave_select_low = 1'b1;
      serialIn = ~serialIn;
      #60;
   endtask : close_frame

   // mode 0, msb first: set while low, both ends sample on the rise
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      #(byteGap);
      for (int i = 7; i >= 0; i--) begin
         serialIn = tx[i];
         #15;
         spiClk = 1'b1;
         rx[i] = serialOut;
         #15;
         spiClk = 1'b0;
      end
   endtask : xfer
endmodule : lbs_spi_host_model
